// ---- logic/fdp_ctrl.sv ----
// fdp_ctrl: flash and debug access protection controller
// assumes: single clock sys_clk; debug host lines arrive as pins and are synchronised here;
// firmware side signals come from logic on sys_clk
`timescale 1ns/1ps
`default_nettype none
module fdp_ctrl #(
   parameter int ROWS = fdp_pkg::FDP_ROWS_DEF,
   parameter int RW   = $clog2(ROWS)
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   // firmware controls
   input  wire logic              fw_dbg_dis,
   input  wire logic              fw_dbg_en,
   input  wire fdp_pkg::fdp_req_t fw_mode_req,
   input  wire logic              fw_secure_set,
   input  wire logic              fw_row_we,
   input  wire logic [RW-1:0]     fw_row_sel,
   input  wire logic              fw_row_rd_prot,
   input  wire logic              fw_row_wr_prot,
   // internal system-call flash operation
   input  wire logic              sc_req,
   input  wire fdp_pkg::fdp_op_t  sc_op,
   // external debug host pins
   input  wire logic              ext_dbg_req,
   input  wire logic              ext_erase_req,
   input  wire logic              ext_test_req,
   input  wire logic              ext_flash_req,
   input  wire logic              ext_flash_wr,
   input  wire logic [RW-1:0]     ext_flash_row,
   // flash erase completion from the flash macro
   input  wire logic              flash_erase_done,
   // access decisions
   output logic                   dbg_grant,
   output logic                   dbg_refuse,
   output logic                   erase_start,
   output logic                   erase_refuse,
   output logic                   test_grant,
   output logic                   flash_grant,
   output logic                   flash_refuse,
   output logic                   sc_grant,
   // status
   output fdp_pkg::fdp_mode_t     mode,
   output logic                   dbg_enabled,
   output logic                   secure_locked,
   output logic                   erased
);
   import fdp_pkg::*;

   fdp_mode_t mode_q;
   fdp_mode_t mode_d;
   logic      dbg_en_q;
   logic      secure_q;
   logic      erased_q;
   logic      erase_busy_q;
   logic      rows_clr;
   logic      rd_prot;
   logic      wr_prot;
   logic      ext_ok;
   logic      dbg_req_s;
   logic      erase_req_s;
   logic      test_req_s;
   logic      flash_req_s;
   logic      flash_wr_s;
   logic [RW-1:0] flash_row_s;
   logic      erase_req_q;
   logic      erase_rise;

   // pin synchronisers for host requests
   fdp_sync #(.W(5 + RW)) u_sync (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .async_i ({ext_dbg_req, ext_erase_req, ext_test_req, ext_flash_req, ext_flash_wr,
                 ext_flash_row}),
      .sync_o  ({dbg_req_s, erase_req_s, test_req_s, flash_req_s, flash_wr_s, flash_row_s})
   );

   // per-row protection table, cleared when a full erase completes
   fdp_rowprot #(.ROWS(ROWS), .RW(RW)) u_rows (
      .sys_clk      (sys_clk),
      .nrst         (nrst),
      .cfg_we       (fw_row_we),
      .cfg_row      (fw_row_sel),
      .cfg_rd_prot  (fw_row_rd_prot),
      .cfg_wr_prot  (fw_row_wr_prot),
      .clr_all      (rows_clr),
      .look_row     (flash_row_s),
      .look_rd_prot (rd_prot),
      .look_wr_prot (wr_prot)
   );

   // host debug and flash access only when open, debug on and not secured
   assign ext_ok = (mode_q == FDP_MODE_OPEN) && dbg_en_q && !secure_q;
   assign rows_clr = erase_busy_q && flash_erase_done;
   assign erase_rise = erase_req_s && !erase_req_q;

   // mode transitions
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         FDP_MODE_OPEN: begin
            if (fw_mode_req == FDP_REQ_TO_PROT) begin
               mode_d = FDP_MODE_PROT;
            end else if (fw_mode_req == FDP_REQ_TO_KILL) begin
               mode_d = FDP_MODE_KILL;
            end
         end
         FDP_MODE_PROT: begin
            if (fw_mode_req == FDP_REQ_TO_OPEN && erased_q) begin
               mode_d = FDP_MODE_OPEN;
            end
         end
         FDP_MODE_KILL: begin
            mode_d = FDP_MODE_KILL;
         end
         default: begin
            mode_d = FDP_MODE_KILL;
         end
      endcase
   end

   // protection mode register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mode_q <= fdp_mode_t'(FDP_MODE_RST);
      end else begin
         mode_q <= mode_d;
      end
   end

   // edge detect on synchronised erase request
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         erase_req_q <= 1'b0;
      end else begin
         erase_req_q <= erase_req_s;
      end
   end

   // full erase tracking; erase is launched by host, kill and security refuse it
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         erase_busy_q <= 1'b0;
         erased_q     <= FDP_ERASED_RST;
      end else begin
         if (erase_rise && mode_q != FDP_MODE_KILL && !secure_q && !erase_busy_q) begin
            erase_busy_q <= 1'b1;
            erased_q     <= 1'b0;
         end else if (rows_clr) begin
            erase_busy_q <= 1'b0;
            erased_q     <= 1'b1;
         end else if (fw_row_we || (sc_req && sc_op != FDP_OP_READ)) begin
            erased_q <= 1'b0;
         end
      end
   end

   // debug enable: firmware only; re-enable needs erase then open mode
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         dbg_en_q <= FDP_DBG_EN_RST;
      end else if (fw_dbg_dis) begin
         dbg_en_q <= 1'b0;
      end else if (fw_dbg_en && (dbg_en_q || (erased_q && mode_q == FDP_MODE_OPEN))) begin
         dbg_en_q <= 1'b1;
      end
   end

   // device security latch, never cleared except by power-on reset of the image
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         secure_q <= FDP_SECURE_RST;
      end else if (fw_secure_set) begin
         secure_q <= 1'b1;
      end
   end

   // registered access decisions
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         dbg_grant    <= 1'b0;
         dbg_refuse   <= 1'b0;
         erase_start  <= 1'b0;
         erase_refuse <= 1'b0;
         test_grant   <= 1'b0;
         flash_grant  <= 1'b0;
         flash_refuse <= 1'b0;
         sc_grant     <= 1'b0;
      end else begin
         dbg_grant    <= dbg_req_s && ext_ok;
         dbg_refuse   <= dbg_req_s && !ext_ok;
         erase_start  <= erase_rise && mode_q != FDP_MODE_KILL && !secure_q && !erase_busy_q;
         erase_refuse <= erase_rise && (mode_q == FDP_MODE_KILL || secure_q);
         test_grant   <= test_req_s && !secure_q;
         flash_grant  <= flash_req_s && ext_ok && !(flash_wr_s ? wr_prot : rd_prot);
         flash_refuse <= flash_req_s && !(ext_ok && !(flash_wr_s ? wr_prot : rd_prot));
         sc_grant     <= sc_req;
      end
   end

   // status outputs
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mode          <= fdp_mode_t'(FDP_MODE_RST);
         dbg_enabled   <= FDP_DBG_EN_RST;
         secure_locked <= FDP_SECURE_RST;
         erased        <= FDP_ERASED_RST;
      end else begin
         mode          <= mode_q;
         dbg_enabled   <= dbg_en_q;
         secure_locked <= secure_q;
         erased        <= erased_q;
      end
   end

   // kill mode is never left
   kill_sticky_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      mode_q == FDP_MODE_KILL |=> mode_q == FDP_MODE_KILL)
      else $error("kill mode was left");

   // protected to open only with erase done, checked on the stored mode
   prot_exit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      mode_q == FDP_MODE_PROT ##1 mode_q == FDP_MODE_OPEN |-> $past(erased_q))
      else $error("left protected without erase");

   // debug refused outside open mode
   dbg_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      dbg_req_s && mode_q != FDP_MODE_OPEN |=> !dbg_grant && dbg_refuse)
      else $error("debug granted while protected");

   // kill reached only from open
   kill_entry_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      mode_q != FDP_MODE_KILL ##1 mode_q == FDP_MODE_KILL |-> $past(mode_q) == FDP_MODE_OPEN)
      else $error("kill entered from wrong mode");

   // host erase refused in kill
   kill_erase_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      erase_rise && mode_q == FDP_MODE_KILL |=> erase_refuse && !erase_start)
      else $error("erase accepted in kill");

   // security never clears and blocks host debug, test and flash grants
   secure_lock_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      secure_q |=> secure_q && !dbg_grant && !test_grant && !flash_grant)
      else $error("security released or bypassed");

   // debug does not return without erase and open mode
   dbg_reen_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !dbg_en_q ##1 dbg_en_q |-> $past(erased_q) && $past(mode_q) == FDP_MODE_OPEN)
      else $error("debug re-enabled illegally");

   // debug disable only on firmware request
   dbg_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      dbg_en_q && !fw_dbg_dis |=> dbg_en_q)
      else $error("debug dropped without firmware");

   // system calls always served
   sc_serve_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      sc_req |=> sc_grant)
      else $error("system call refused");

   // protected row refuses host access
   row_prot_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      flash_req_s && (flash_wr_s ? wr_prot : rd_prot) |=> flash_refuse && !flash_grant)
      else $error("protected row accessed");

   // no request leaves mode unchanged
   mode_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      fw_mode_req == FDP_REQ_NONE |=> mode_q == $past(mode_q))
      else $error("mode changed without request");

   // open mode with debug on and no security grants debug
   open_free_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      dbg_req_s && ext_ok |=> dbg_grant)
      else $error("open mode refused debug");

   // firmware request moves open to protected
   prot_entry_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      mode_q == FDP_MODE_OPEN && fw_mode_req == FDP_REQ_TO_PROT |=> mode_q == FDP_MODE_PROT)
      else $error("protect request not taken");

   // firmware debug-off always takes effect
   dbg_dis_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      fw_dbg_dis |=> !dbg_en_q)
      else $error("debug stayed on after firmware off");

   // finished full erase leaves no row protected
   row_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      rows_clr |=> !rd_prot && !wr_prot)
      else $error("row protection kept after erase");
endmodule
`default_nettype wire

// ---- logic/fdp_pkg.sv ----
// fdp_pkg: shared constants and types for the flash and debug protection controller
// assumes: nothing beyond a SystemVerilog compiler
package fdp_pkg;

   // protection modes, encoded as stored in the nonvolatile image
   typedef enum logic [1:0] {
      FDP_MODE_OPEN,
      FDP_MODE_PROT,
      FDP_MODE_KILL
   } fdp_mode_t;

   // mode change requests issued by firmware
   typedef enum logic [1:0] {
      FDP_REQ_NONE,
      FDP_REQ_TO_OPEN,
      FDP_REQ_TO_PROT,
      FDP_REQ_TO_KILL
   } fdp_req_t;

   // flash operation kinds
   typedef enum logic [1:0] {
      FDP_OP_READ,
      FDP_OP_WRITE,
      FDP_OP_ERASE
   } fdp_op_t;

   // reset values
   localparam logic [1:0] FDP_MODE_RST   = 2'h0;
   localparam logic       FDP_DBG_EN_RST = 1'h1;
   localparam logic       FDP_SECURE_RST = 1'h0;
   localparam logic       FDP_ERASED_RST = 1'h0;

   // synchroniser depth for pin inputs
   localparam int FDP_SYNC_STAGES = 2;

   // default row count
   localparam int FDP_ROWS_DEF = 256;

endpackage

// ---- logic/fdp_sync.sv ----
// fdp_sync: two flip-flop synchroniser for a vector of pin levels
// assumes: inputs are asynchronous levels; outputs are used on sys_clk
`timescale 1ns/1ps
`default_nettype none
module fdp_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         nrst,
   // levels
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ---- logic/fdp_rowprot.sv ----
// fdp_rowprot: per row read and write protection bits with lookup
// assumes: row bits are loaded by firmware; all inputs on sys_clk
`timescale 1ns/1ps
`default_nettype none
module fdp_rowprot #(
   parameter int ROWS = 256,
   parameter int RW   = $clog2(ROWS)
) (
   // clock and reset
   input  wire logic          sys_clk,
   input  wire logic          nrst,
   // configuration write
   input  wire logic          cfg_we,
   input  wire logic [RW-1:0] cfg_row,
   input  wire logic          cfg_rd_prot,
   input  wire logic          cfg_wr_prot,
   input  wire logic          clr_all,
   // lookup
   input  wire logic [RW-1:0] look_row,
   output logic               look_rd_prot,
   output logic               look_wr_prot
);
   logic [ROWS-1:0] rd_prot_q;
   logic [ROWS-1:0] wr_prot_q;

   // one pair of bits per row, cleared together on full clear
   for (genvar i = 0; i < ROWS; i++) begin : g_row
      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            rd_prot_q[i] <= 1'b0;
            wr_prot_q[i] <= 1'b0;
         end else if (clr_all) begin
            rd_prot_q[i] <= 1'b0;
            wr_prot_q[i] <= 1'b0;
         end else if (cfg_we && cfg_row == RW'(i)) begin
            rd_prot_q[i] <= cfg_rd_prot;
            wr_prot_q[i] <= cfg_wr_prot;
         end
      end
   end

   // indexed lookup
   assign look_rd_prot = rd_prot_q[look_row];
   assign look_wr_prot = wr_prot_q[look_row];
endmodule
`default_nettype wire

// ---- tb/fdp_host.sv ----
// fdp_host: behavioural external debug and programming host driving the access pins
// assumes: the controller synchronises every pin; calls come just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module fdp_host #(
   parameter int RW = 4
) (
   // request pins
   output logic          ext_dbg_req,
   output logic          ext_erase_req,
   output logic          ext_test_req,
   output logic          ext_flash_req,
   // flash access qualifiers
   output logic          ext_flash_wr,
   output logic [RW-1:0] ext_flash_row
);
   // host starts idle with no request raised
   initial begin
      {ext_dbg_req, ext_erase_req, ext_test_req, ext_flash_req} = 4'h0;
      ext_flash_wr  = 1'h0;
      ext_flash_row = '0;
   end
   // raise one request level: 0 debug, 1 erase, 2 test, 3 flash
   // the host has no pin that switches debug off; erase is its step of the re-enable
   task automatic raise(input int k, input logic wr, input logic [RW-1:0] row);
      ext_flash_wr  = wr;
      ext_flash_row = row;
      ext_dbg_req   = (k == 0);
      ext_erase_req = (k == 1);
      ext_test_req  = (k == 2);
      ext_flash_req = (k == 3);
   endtask
   // drop requests; qualifiers flip so stale values never pass for valid ones
   task automatic drop();
      {ext_dbg_req, ext_erase_req, ext_test_req, ext_flash_req} = 4'h0;
      ext_flash_wr  = ~ext_flash_wr;
      ext_flash_row = ~ext_flash_row;
   endtask
endmodule
`default_nettype wire

// ---- tb/fdp_ctrl_bench.sv ----
// fdp_ctrl_bench: self-checking bench for the flash and debug protection controller
// assumes: fdp_pkg, the controller and fdp_host are compiled first
`timescale 1ns/1ps
`default_nettype none
module fdp_ctrl_bench;
   import fdp_pkg::*;
   localparam int RW = 4;
   logic          sys_clk, nrst, fw_dbg_dis, fw_dbg_en, fw_secure_set, fw_row_we;
   logic          fw_row_rd_prot, fw_row_wr_prot, sc_req, flash_erase_done;
   logic [RW-1:0] fw_row_sel, ext_flash_row;
   fdp_req_t      fw_mode_req;
   fdp_op_t       sc_op;
   fdp_mode_t     mode;
   logic          ext_dbg_req, ext_erase_req, ext_test_req, ext_flash_req, ext_flash_wr;
   logic          dbg_grant, dbg_refuse, erase_start, erase_refuse, test_grant;
   logic          flash_grant, flash_refuse, sc_grant, dbg_enabled, secure_locked, erased;
   int            n_fail, n_tests;

   // design under test with a short row table
   fdp_ctrl #(.ROWS(16)) dut (
      .sys_clk(sys_clk), .nrst(nrst), .fw_dbg_dis(fw_dbg_dis), .fw_dbg_en(fw_dbg_en),
      .fw_mode_req(fw_mode_req), .fw_secure_set(fw_secure_set), .fw_row_we(fw_row_we),
      .fw_row_sel(fw_row_sel), .fw_row_rd_prot(fw_row_rd_prot),
      .fw_row_wr_prot(fw_row_wr_prot), .sc_req(sc_req), .sc_op(sc_op),
      .ext_dbg_req(ext_dbg_req), .ext_erase_req(ext_erase_req),
      .ext_test_req(ext_test_req), .ext_flash_req(ext_flash_req),
      .ext_flash_wr(ext_flash_wr), .ext_flash_row(ext_flash_row),
      .flash_erase_done(flash_erase_done), .dbg_grant(dbg_grant), .dbg_refuse(dbg_refuse),
      .erase_start(erase_start), .erase_refuse(erase_refuse), .test_grant(test_grant),
      .flash_grant(flash_grant), .flash_refuse(flash_refuse), .sc_grant(sc_grant),
      .mode(mode), .dbg_enabled(dbg_enabled), .secure_locked(secure_locked),
      .erased(erased));

   // external host model on the pins
   fdp_host #(.RW(RW)) host (
      .ext_dbg_req(ext_dbg_req), .ext_erase_req(ext_erase_req),
      .ext_test_req(ext_test_req), .ext_flash_req(ext_flash_req),
      .ext_flash_wr(ext_flash_wr), .ext_flash_row(ext_flash_row));

   // 50 MHz clock
   always #10 sys_clk = ~sys_clk;

   // step n edges, then settle inputs just after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // compare one bit
   task automatic chk(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s exp %b got %b", nm, e, g);
      end
   endtask
   // compare the protection mode
   task automatic chk_m(input fdp_mode_t e);
      n_tests++;
      if (mode !== e) begin
         n_fail++;
         $display("FAIL mode exp %h got %h", e, mode);
      end
   endtask
   // firmware mode request, one cycle, then wait for the status output
   task automatic mreq(input fdp_req_t r);
      fw_mode_req = r;
      tick(1);
      fw_mode_req = FDP_REQ_NONE;
      tick(1);
   endtask
   // firmware bits: 0 debug off, 1 debug on, 2 security lock
   task automatic fwb(input logic [2:0] m);
      {fw_secure_set, fw_dbg_en, fw_dbg_dis} = m;
      tick(1);
      {fw_secure_set, fw_dbg_en, fw_dbg_dis} = 3'h0;
      tick(1);
   endtask
   // firmware row protection write
   task automatic row(input logic [RW-1:0] r, input logic rd, input logic wr);
      {fw_row_we, fw_row_sel, fw_row_rd_prot, fw_row_wr_prot} = {1'h1, r, rd, wr};
      tick(1);
      fw_row_we = 1'h0;
      tick(1);
   endtask
   // each system-call operation is granted one edge later
   task automatic sc_all();
      for (int i = 0; i < 3; i++) begin
         sc_req = 1'h1;
         sc_op  = fdp_op_t'(i);
         tick(1);
         chk("sc_grant", 1'h1, sc_grant);
         sc_req = 1'h0;
         tick(1);
      end
   endtask
   // host access of kind k; answer stands three edges after the pin rises
   task automatic acc(input int k, input logic wr, input logic [RW-1:0] r,
                      input logic eg, input logic er);
      logic g;
      logic f;
      host.raise(k, wr, r);
      tick(3);
      g = (k == 0) ? dbg_grant : (k == 1) ? erase_start : (k == 2) ? test_grant : flash_grant;
      f = (k == 0) ? dbg_refuse : (k == 1) ? erase_refuse : (k == 2) ? 1'h0 : flash_refuse;
      chk("grant", eg, g);
      chk("refuse", er, f);
      host.drop();
      tick(3);
   endtask
   // asynchronous reset held for two cycles
   task automatic do_reset();
      nrst = 1'h0;
      tick(2);
      nrst = 1'h1;
   endtask
   // verdict and end of run
   task automatic wrap_up();
      if (n_fail == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (3000) @(posedge sys_clk);
      n_fail++;
      wrap_up();
   end

   // test sequence
   initial begin
      {sys_clk, fw_dbg_dis, fw_dbg_en, fw_secure_set, fw_row_we} = 5'h0;
      {fw_row_rd_prot, fw_row_wr_prot, sc_req, flash_erase_done} = 4'h0;
      fw_row_sel  = '0;
      fw_mode_req = FDP_REQ_NONE;
      sc_op       = FDP_OP_READ;
      n_fail      = 0;
      n_tests     = 0;
      do_reset();
      tick(1);
      chk_m(FDP_MODE_OPEN);
      chk("dbg_enabled", 1'h1, dbg_enabled);
      acc(0, 1'h0, 4'h0, 1'h1, 1'h0);
      acc(2, 1'h0, 4'h0, 1'h1, 1'h0);
      sc_all();
      row(4'h5, 1'h0, 1'h1);
      row(4'h6, 1'h1, 1'h0);
      acc(3, 1'h1, 4'h5, 1'h0, 1'h1);
      acc(3, 1'h0, 4'h5, 1'h1, 1'h0);
      acc(3, 1'h0, 4'h6, 1'h0, 1'h1);
      acc(3, 1'h1, 4'h6, 1'h1, 1'h0);
      fwb(3'h1);
      chk("dbg_enabled", 1'h0, dbg_enabled);
      acc(0, 1'h0, 4'h0, 1'h0, 1'h1);
      fwb(3'h2);
      chk("dbg_enabled", 1'h0, dbg_enabled);
      mreq(FDP_REQ_TO_PROT);
      chk_m(FDP_MODE_PROT);
      acc(0, 1'h0, 4'h0, 1'h0, 1'h1);
      mreq(FDP_REQ_TO_KILL);
      chk_m(FDP_MODE_PROT);
      mreq(FDP_REQ_TO_OPEN);
      chk_m(FDP_MODE_PROT);
      sc_all();
      acc(1, 1'h0, 4'h0, 1'h1, 1'h0);
      flash_erase_done = 1'h1;
      tick(1);
      flash_erase_done = 1'h0;
      tick(1);
      chk("erased", 1'h1, erased);
      mreq(FDP_REQ_TO_OPEN);
      chk_m(FDP_MODE_OPEN);
      fwb(3'h2);
      chk("dbg_enabled", 1'h1, dbg_enabled);
      acc(0, 1'h0, 4'h0, 1'h1, 1'h0);
      acc(3, 1'h1, 4'h5, 1'h1, 1'h0);
      mreq(FDP_REQ_TO_OPEN);
      chk_m(FDP_MODE_OPEN);
      mreq(FDP_REQ_TO_KILL);
      chk_m(FDP_MODE_KILL);
      acc(0, 1'h0, 4'h0, 1'h0, 1'h1);
      acc(1, 1'h0, 4'h0, 1'h0, 1'h1);
      mreq(FDP_REQ_TO_OPEN);
      chk_m(FDP_MODE_KILL);
      sc_all();
      do_reset();
      fwb(3'h4);
      chk("secure_locked", 1'h1, secure_locked);
      acc(2, 1'h0, 4'h0, 1'h0, 1'h0);
      acc(0, 1'h0, 4'h0, 1'h0, 1'h1);
      acc(1, 1'h0, 4'h0, 1'h0, 1'h1);
      wrap_up();
   end
endmodule
`default_nettype wire
